// [common/fsid_defs.svh]
// offsets, field positions, reset values and encodings for the fp/simd id register bank
`ifndef FSID_DEFS_SVH
`define FSID_DEFS_SVH

// 64-bit-state system-register encodings {op0,op1,crn,crm,op2}
`define FSID_ENC_ID_ONE_A64 16'hC019
`define FSID_ENC_ID_TWO_A64 16'hC01A
`define FSID_ENC_EXC_A64 16'hE298

// 32-bit-state register selectors (arbitrary numbering of the bank's own select port)
`define FSID_SEL_SYS_ID 4'h0
`define FSID_SEL_STAT_CTRL 4'h1
`define FSID_SEL_ID_ZERO 4'h2
`define FSID_SEL_ID_ONE 4'h3
`define FSID_SEL_ID_TWO 4'h4
`define FSID_SEL_EXC 4'h5
`define FSID_SEL_INSN_FIRST 4'h6
`define FSID_SEL_INSN_SECOND 4'h7

// feature-id one fields
`define FSID_ONE_FMAC 4'h1
`define FSID_ONE_SCALAR_HALF 4'h2
`define FSID_ONE_VEC_FIELD 4'h1
`define FSID_ONE_NAN_PROP 4'h1
`define FSID_ONE_DENORM 4'h1

// feature-id two fields
`define FSID_TWO_SCALAR_MISC 4'h4
`define FSID_TWO_VECTOR_MISC 4'h3

// reset and constant values
`define FSID_ID_ZERO_VAL 32'h10110222
`define FSID_ID_ONE_VAL 32'h12111111
`define FSID_ID_TWO_RST 32'h00000043
`define FSID_STAT_CTRL_RST 32'h00000000
`define FSID_EXC_RST 32'h00000700

// exception-control field positions and masks
`define FSID_EXC_ASYNC_BIT 31
`define FSID_EXC_EN_BIT 30
`define FSID_EXC_WMASK 32'h40000000
`define FSID_EXC_ONES 32'h00000700

`endif

// [common/fsid_pkg.sv]
// types for the fp/simd feature-id register bank
package fsid_pkg;

	typedef enum logic [1:0]
	{
		FSID_EL0 = 2'h0,
		FSID_EL1 = 2'h1,
		FSID_EL2 = 2'h2,
		FSID_EL3 = 2'h3
	} fsid_el_t;

	typedef struct packed
	{
		logic [1:0] op0;
		logic [2:0] op1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] op2;
	} fsid_enc_t;

	typedef struct packed
	{
		logic valid;
		logic write;
		logic a64;
		fsid_el_t el;
		fsid_enc_t enc;
		logic [3:0] sel;
		logic [31:0] wdata;
	} fsid_req_t;

	typedef struct packed
	{
		logic done;
		logic undef;
		logic [31:0] rdata;
	} fsid_rsp_t;

	typedef enum logic [2:0]
	{
		FSID_ST_IDLE = 3'b001,
		FSID_ST_ANSWER = 3'b010,
		FSID_ST_TRAP = 3'b100
	} fsid_state_t;

endpackage

// [design/fsid_regs.sv]
// fp/simd feature-id and exception-control system register bank
`timescale 1ns/1ps
`default_nettype none
`include "fsid_defs.svh"

module fsid_regs #(
	// arbitrary neutral identity value, not any real part
	parameter logic [31:0] SYS_ID_VALUE = 32'h00001000
)(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire fsid_pkg::fsid_req_t i_req,
	input wire logic i_el1_a64,
	output var fsid_pkg::fsid_rsp_t o_rsp,
	output logic o_busy,
	output logic o_fp_enable
);
	import fsid_pkg::*;

	// ----------------------------------------
	// constant register images
	// ----------------------------------------
	logic [31:0] id_one_a64;
	logic [31:0] id_two_a64;
	logic [15:0] vec_fields;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_vec
			// every vector-unit field reports the same implemented level
			assign vec_fields[gi*4 +: 4] = `FSID_ONE_VEC_FIELD;
		end
	endgenerate

	assign id_one_a64 = {`FSID_ONE_FMAC, `FSID_ONE_SCALAR_HALF,
		vec_fields,
		`FSID_ONE_NAN_PROP,
		`FSID_ONE_DENORM};
	assign id_two_a64 = {24'h000000, `FSID_TWO_SCALAR_MISC,
		`FSID_TWO_VECTOR_MISC};

	// ----------------------------------------
	// writable state
	// ----------------------------------------
	logic [31:0] fp_exception_control;
	logic [31:0] fp_status_and_control;
	logic [31:0] simd_fp_feature_id_two;
	fsid_state_t state;
	fsid_state_t next_state;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic [15:0] enc_flat;
	logic hit_one_a64;
	logic hit_two_a64;
	logic hit_exc_a64;
	logic sel_known;
	logic sel_insn;
	logic sel_ro;
	logic el_ok;
	logic legal;
	logic do_wr;
	logic [31:0] rd_mux;

	assign enc_flat = i_req.enc;
	assign hit_one_a64 = i_req.a64 && (enc_flat == `FSID_ENC_ID_ONE_A64);
	assign hit_two_a64 = i_req.a64 && (enc_flat == `FSID_ENC_ID_TWO_A64);
	assign hit_exc_a64 = i_req.a64 && (enc_flat == `FSID_ENC_EXC_A64);

	assign sel_known = !i_req.a64 && (i_req.sel <= `FSID_SEL_EXC);
	assign sel_insn = !i_req.a64 && ((i_req.sel == `FSID_SEL_INSN_FIRST) ||
		(i_req.sel == `FSID_SEL_INSN_SECOND));
	assign sel_ro = (i_req.sel == `FSID_SEL_SYS_ID) || (i_req.sel == `FSID_SEL_ID_ZERO) ||
		(i_req.sel == `FSID_SEL_ID_ONE);

	// 64-bit feature ids: EL1 upward, read only; exception view: EL2 upward, rw
	always_comb
	begin
		el_ok = 1'b0;
		if (hit_one_a64 || hit_two_a64)
		begin
			el_ok = (i_req.el != FSID_EL0) && !i_req.write;
		end
		else if (hit_exc_a64)
		begin
			el_ok = (i_req.el == FSID_EL2) || (i_req.el == FSID_EL3);
		end
		else if (sel_known)
		begin
			// finer 32-bit trap controls live outside this bank
			el_ok = !(i_req.write && sel_ro);
		end
	end

	assign legal = el_ok && !sel_insn;
	assign do_wr = i_req.valid && legal && i_req.write && (state == FSID_ST_IDLE);

	always_comb
	begin
		rd_mux = 32'h00000000;
		if (hit_one_a64)
		begin
			rd_mux = id_one_a64;
		end
		else if (hit_two_a64)
		begin
			rd_mux = id_two_a64;
		end
		else if (hit_exc_a64)
		begin
			rd_mux = fp_exception_control;
		end
		else
		begin
			case (i_req.sel)
				`FSID_SEL_SYS_ID: rd_mux = SYS_ID_VALUE;
				`FSID_SEL_STAT_CTRL: rd_mux = fp_status_and_control;
				`FSID_SEL_ID_ZERO: rd_mux = `FSID_ID_ZERO_VAL;
				`FSID_SEL_ID_ONE: rd_mux = `FSID_ID_ONE_VAL;
				`FSID_SEL_ID_TWO: rd_mux = simd_fp_feature_id_two;
				`FSID_SEL_EXC: rd_mux = fp_exception_control;
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// register updates
	// ----------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			fp_exception_control <= `FSID_EXC_RST;
		end
		else if (do_wr && (hit_exc_a64 || (sel_known && i_req.sel == `FSID_SEL_EXC)))
		begin
			// bit 31 stays zero, [10:8] stay one, only the enable bit stores
			fp_exception_control <= (i_req.wdata & `FSID_EXC_WMASK) | `FSID_EXC_ONES;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			fp_status_and_control <= `FSID_STAT_CTRL_RST;
		end
		else if (do_wr && sel_known && i_req.sel == `FSID_SEL_STAT_CTRL)
		begin
			fp_status_and_control <= i_req.wdata;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			simd_fp_feature_id_two <= `FSID_ID_TWO_RST;
		end
		else if (do_wr && sel_known && i_req.sel == `FSID_SEL_ID_TWO)
		begin
			simd_fp_feature_id_two <= i_req.wdata;
		end
	end

	// ----------------------------------------
	// answer sequencing
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			FSID_ST_IDLE:
			begin
				if (i_req.valid)
				begin
					next_state = legal ? FSID_ST_ANSWER : FSID_ST_TRAP;
				end
			end
			FSID_ST_ANSWER: next_state = FSID_ST_IDLE;
			FSID_ST_TRAP: next_state = FSID_ST_IDLE;
			default: next_state = FSID_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state <= FSID_ST_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_rsp <= '0;
		end
		else
		begin
			o_rsp.done <= (state == FSID_ST_IDLE) && i_req.valid;
			o_rsp.undef <= (state == FSID_ST_IDLE) && i_req.valid && !legal;
			// a trapped or write access returns zero data
			o_rsp.rdata <= ((state == FSID_ST_IDLE) && i_req.valid && legal && !i_req.write) ?
				rd_mux : 32'h00000000;
		end
	end

	assign o_busy = (state != FSID_ST_IDLE);

	// the enable only gates 32-bit execution while EL1 is not in 64-bit state
	assign o_fp_enable = i_el1_a64 || fp_exception_control[`FSID_EXC_EN_BIT];

endmodule
`default_nettype wire

// [testbench/fsid_regs_asserts.sv]
// port assertions for the fp/simd feature-id register bank
`timescale 1ns/1ps
`default_nettype none
module fsid_regs_asserts (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire fsid_pkg::fsid_req_t i_req,
	input wire logic i_el1_a64,
	input wire fsid_pkg::fsid_rsp_t o_rsp,
	input wire logic o_busy,
	input wire logic o_fp_enable
);
	import fsid_pkg::*;
	logic tk;
	logic a64;
	assign tk = i_req.valid && !o_busy;
	assign a64 = tk && i_req.a64;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);
	property p_answer; tk |=> o_rsp.done && o_busy; endproperty
	a_answer: assert property (p_answer) else $error("no answer after request");
	property p_quiet; !$past(tk) |-> !o_rsp.done; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without request");
	property p_one; a64 && !i_req.write && i_req.enc == 16'hC019 && i_req.el != FSID_EL0
		|=> !o_rsp.undef && o_rsp.rdata == 32'h12111111; endproperty
	a_one: assert property (p_one) else $error("id one read wrong");
	property p_two; a64 && !i_req.write && i_req.enc == 16'hC01A && i_req.el != FSID_EL0
		|=> !o_rsp.undef && o_rsp.rdata == 32'h00000043; endproperty
	a_two: assert property (p_two) else $error("id two read wrong");
	property p_el0; a64 && i_req.el == FSID_EL0 |=> o_rsp.undef; endproperty
	a_el0: assert property (p_el0) else $error("lowest level not trapped");
	property p_exc; a64 && i_req.enc == 16'hE298 && !i_req.el[1] |=> o_rsp.undef; endproperty
	a_exc: assert property (p_exc) else $error("control view open below level two");
	property p_insn; tk && !i_req.a64 && i_req.sel[3:1] == 3'h3 |=> o_rsp.undef; endproperty
	a_insn: assert property (p_insn) else $error("instruction register answered");
	property p_trap; o_rsp.undef |-> o_rsp.done && o_rsp.rdata == 32'h0; endproperty
	a_trap: assert property (p_trap) else $error("trap carries data");
	property p_en; i_el1_a64 |-> o_fp_enable; endproperty
	a_en: assert property (p_en) else $error("unit disabled in wide state");
	c_wr: cover property (tk && i_req.write);
	c_trap: cover property (o_rsp.undef);
	c_en: cover property (o_fp_enable && !i_el1_a64);
endmodule
`default_nettype wire

// [testbench/fsid_regs_bench.sv]
// self-checking bench for the fp/simd feature-id register bank
`timescale 1ns/1ps
`default_nettype none
module fsid_regs_bench;
	import fsid_pkg::*;
	// arbitrary identity value, not any real part
	localparam logic [31:0] SYS_ID = 32'h00001000;
	logic i_mclk;
	logic i_rst_b;
	logic i_el1_a64;
	fsid_req_t i_req;
	fsid_rsp_t o_rsp;
	logic o_busy;
	logic o_fp_enable;
	int error_cnt;
	int checked;
	fsid_regs #(.SYS_ID_VALUE(SYS_ID)) fsid_regs_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_req(i_req), .i_el1_a64(i_el1_a64), .o_rsp(o_rsp), .o_busy(o_busy),
		.o_fp_enable(o_fp_enable));
	initial
	begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x)
		begin
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
			error_cnt++;
		end
	endtask
	// -------------------------------------------------------------
	// one request, answer judged one cycle later, busy cycle skipped
	// -------------------------------------------------------------
	task acc(input logic w, a, input logic [1:0] e, input logic [15:0] adr,
		input logic [31:0] wd, input logic xu, input logic [31:0] xr);
		i_req = {1'b1, w, a, e, adr, adr[3:0], wd};
		@(posedge i_mclk);
		#1 i_req.valid = 1'b0;
		chk("done", 32'h1, o_rsp.done);
		chk("busy", 32'h1, o_busy);
		chk("undef", xu, o_rsp.undef);
		chk("rdata", xr, o_rsp.rdata);
		@(posedge i_mclk);
		#1;
	endtask
	task t_reset;
		acc(0, 0, 1, 16'h0, 32'h0, 0, SYS_ID);
		acc(0, 0, 1, 16'h1, 32'h0, 0, 32'h0);
		acc(0, 0, 1, 16'h2, 32'h0, 0, 32'h10110222);
		acc(0, 0, 1, 16'h3, 32'h0, 0, 32'h12111111);
		acc(0, 0, 1, 16'h4, 32'h0, 0, 32'h43);
		acc(0, 0, 1, 16'h5, 32'h0, 0, 32'h700);
		chk("enable", 32'h0, o_fp_enable);
		$display("reset values done");
	endtask
	task t_ids;
		acc(0, 1, 1, 16'hC019, 32'h0, 0, 32'h12111111);
		acc(0, 1, 3, 16'hC019, 32'h0, 0, 32'h12111111);
		acc(0, 1, 2, 16'hC01A, 32'h0, 0, 32'h43);
		acc(0, 1, 0, 16'hC019, 32'h0, 1, 32'h0);
		acc(0, 1, 0, 16'hC01A, 32'h0, 1, 32'h0);
		acc(1, 1, 1, 16'hC01A, 32'hFFFFFFFF, 1, 32'h0);
		$display("feature id reads done");
	endtask
	task t_exc;
		acc(1, 1, 2, 16'hE298, 32'hFFFFFFFF, 0, 32'h0);
		chk("enable", 32'h1, o_fp_enable);
		acc(0, 1, 3, 16'hE298, 32'h0, 0, 32'h40000700);
		acc(1, 1, 1, 16'hE298, 32'h0, 1, 32'h0);
		acc(0, 1, 3, 16'hE298, 32'h0, 0, 32'h40000700);
		acc(1, 1, 3, 16'hE298, 32'h0, 0, 32'h0);
		chk("enable", 32'h0, o_fp_enable);
		i_el1_a64 = 1'b1;
		#1 chk("enable", 32'h1, o_fp_enable);
		i_el1_a64 = 1'b0;
		$display("exception control done");
	endtask
	task t_w32;
		acc(1, 0, 1, 16'h1, 32'hA5A5F00F, 0, 32'h0);
		acc(0, 0, 1, 16'h1, 32'h0, 0, 32'hA5A5F00F);
		acc(1, 0, 1, 16'h4, 32'h5A, 0, 32'h0);
		acc(0, 0, 1, 16'h4, 32'h0, 0, 32'h5A);
		acc(1, 0, 1, 16'h3, 32'h0, 1, 32'h0);
		acc(1, 0, 1, 16'h0, 32'h0, 1, 32'h0);
		acc(0, 0, 1, 16'h6, 32'h0, 1, 32'h0);
		acc(1, 0, 1, 16'h7, 32'h0, 1, 32'h0);
		$display("narrow state writes done");
	endtask
	task t_rerst;
		i_rst_b = 1'b0;
		repeat (2) @(posedge i_mclk);
		#1 i_rst_b = 1'b1;
		acc(0, 0, 1, 16'h1, 32'h0, 0, 32'h0);
		acc(0, 0, 1, 16'h4, 32'h0, 0, 32'h43);
		acc(0, 0, 1, 16'h5, 32'h0, 0, 32'h700);
		$display("second reset done");
	endtask
	initial
	begin
		error_cnt = 0;
		checked = 0;
		i_rst_b = 1'b0;
		i_el1_a64 = 1'b0;
		i_req = '0;
		repeat (20) @(posedge i_mclk);
		#1 i_rst_b = 1'b1;
		t_reset;
		t_ids;
		t_exc;
		t_w32;
		t_rerst;
		give_verdict;
	end
endmodule
bind fsid_regs fsid_regs_asserts fsid_regs_asserts_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
	.i_req(i_req), .i_el1_a64(i_el1_a64), .o_rsp(o_rsp), .o_busy(o_busy),
	.o_fp_enable(o_fp_enable));
`default_nettype wire
